// *** airs_pkg.sv ***
// Package for the converter input and reference select block.
// Assumes an 8-bit special function register bus with 8-bit addresses.
package airs_pkg;
    localparam logic [7:0] AIRS_INSEL_ADDR = 8'hbb;
    localparam logic [7:0] AIRS_REFCTL_ADDR = 8'hd1;
    localparam logic [4:0] AIRS_INSEL_RST = 5'h1f;
    localparam logic [7:0] AIRS_INSEL_WMASK = 8'h1f;
    localparam logic [7:0] AIRS_REFCTL_WMASK = 8'hbc;
    localparam logic [7:0] AIRS_REFCTL_RST = 8'h18;
    localparam int AIRS_LVL_BIT = 7;
    localparam int AIRS_GND_BIT = 5;
    localparam int AIRS_SRC_LSB = 3;
    localparam int AIRS_TEMP_BIT = 2;
    localparam logic [4:0] AIRS_SEL_TEMP = 5'h10;
    localparam logic [4:0] AIRS_SEL_LDO = 5'h11;
    localparam logic [4:0] AIRS_SEL_VDD = 5'h12;
    localparam logic [4:0] AIRS_SEL_GND = 5'h13;
    localparam int AIRS_NUM_EXT = 16;
    localparam int AIRS_NUM_SEL = 20;
    typedef enum logic [3:0]
    {
        AIRS_REF_PIN = 4'h1,
        AIRS_REF_VDD = 4'h2,
        AIRS_REF_DIG = 4'h4,
        AIRS_REF_INT = 4'h8
    } airs_ref_e;
endpackage

// *** airs_mux_decode.sv ***
// One-hot decode of the five-bit positive input selection code.
// Purely combinational; the parent registers the result.
`timescale 1ns/100ps
`default_nettype none
module airs_mux_decode
    import airs_pkg::*;
#(
    parameter int NUM_SEL = AIRS_NUM_SEL
)
(
    input wire logic [4:0] code_i,        // Selection code
    output logic [NUM_SEL-1:0] onehot_o   // One select per source
);
    // Reserved codes fall through with no match, so no switch closes
    for (genvar g = 0; g < NUM_SEL; g++)
    begin : g_dec
        assign onehot_o[g] = (code_i == 5'(g));
    end
endmodule
`default_nettype wire

// *** airs_top.sv ***
// Converter input and reference select registers on the special function register bus.
// Assumes single-cycle register reads and writes from the core, system clock and reset.
// Functional notes
// - Codes 0 to 15 connect external channels 0 to 15 to the positive mux input.
// - Codes 16 to 19 connect temp sensor, regulator, supply and ground.
// - Reserved codes 20 to 31 close no switch at all.
// - Bit 7 of the reference register picks the low or high internal reference level.
// - Bit 5 picks ordinary ground or the analog ground pin.
// - Bits 4:3 route the reference from pin, supply, digital supply or internal.
// - Bit 2 enables the temperature sensor.
`timescale 1ns/100ps
`default_nettype none
module airs_top
    import airs_pkg::*;
#(
    parameter int NUM_EXT = AIRS_NUM_EXT
)
(
    input wire logic clk_i,                    // System clock
    input wire logic arst_n_i,                 // Async reset, active low
    input wire logic [7:0] sfr_addr_i,         // Register address
    input wire logic sfr_wr_i,                 // Write strobe
    input wire logic sfr_rd_i,                 // Read strobe
    input wire logic [7:0] sfr_wdata_i,        // Write data
    output logic [7:0] sfr_rdata_o,            // Read data, registered
    output logic [NUM_EXT-1:0] ext_chan_sel_o, // External channel switches
    output logic temp_chan_sel_o,              // Temp sensor to mux
    output logic ldo_chan_sel_o,               // Regulator output to mux
    output logic vdd_chan_sel_o,               // Supply to mux
    output logic gnd_chan_sel_o,               // Ground to mux
    output logic internal_ref_level_o,         // 0 low level, 1 high level
    output logic ground_ref_select_o,          // 0 ground pin, 1 analog ground pin
    output logic [3:0] voltage_ref_source_o,   // One-hot reference route
    output logic temp_sensor_enable_o          // Temp sensor power
);
    logic [4:0] insel_q;
    logic [7:0] refctl_q;
    logic [AIRS_NUM_SEL-1:0] sel_oh;
    logic [3:0] ref_oh;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            insel_q <= AIRS_INSEL_RST;
        else if (sfr_wr_i && sfr_addr_i == AIRS_INSEL_ADDR)
            insel_q <= sfr_wdata_i[4:0];
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            refctl_q <= AIRS_REFCTL_RST;
        else if (sfr_wr_i && sfr_addr_i == AIRS_REFCTL_ADDR)
            refctl_q <= sfr_wdata_i & AIRS_REFCTL_WMASK;
    end

    // Unmapped addresses read zero so stray reads cannot alias
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            sfr_rdata_o <= 8'h00;
        else if (sfr_rd_i && sfr_addr_i == AIRS_INSEL_ADDR)
            sfr_rdata_o <= {3'h0, insel_q};
        else if (sfr_rd_i && sfr_addr_i == AIRS_REFCTL_ADDR)
            sfr_rdata_o <= refctl_q;
        else
            sfr_rdata_o <= 8'h00;
    end

    airs_mux_decode #(
        .NUM_SEL(AIRS_NUM_SEL)
    ) u_dec (
        .code_i(insel_q),
        .onehot_o(sel_oh)
    );

    always_comb
    begin
        case (refctl_q[AIRS_SRC_LSB +: 2])
            2'b00: ref_oh = AIRS_REF_PIN;
            2'b01: ref_oh = AIRS_REF_VDD;
            2'b10: ref_oh = AIRS_REF_DIG;
            default: ref_oh = AIRS_REF_INT;
        endcase
    end

    // Outputs lag the register by one cycle so every switch drive is a flop
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ext_chan_sel_o <= '0;
            temp_chan_sel_o <= 1'b0;
            ldo_chan_sel_o <= 1'b0;
            vdd_chan_sel_o <= 1'b0;
            gnd_chan_sel_o <= 1'b0;
        end
        else
        begin
            ext_chan_sel_o <= sel_oh[NUM_EXT-1:0];
            temp_chan_sel_o <= sel_oh[AIRS_SEL_TEMP];
            ldo_chan_sel_o <= sel_oh[AIRS_SEL_LDO];
            vdd_chan_sel_o <= sel_oh[AIRS_SEL_VDD];
            gnd_chan_sel_o <= sel_oh[AIRS_SEL_GND];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            internal_ref_level_o <= 1'b0;
            ground_ref_select_o <= 1'b0;
            voltage_ref_source_o <= AIRS_REF_INT;
            temp_sensor_enable_o <= 1'b0;
        end
        else
        begin
            internal_ref_level_o <= refctl_q[AIRS_LVL_BIT];
            ground_ref_select_o <= refctl_q[AIRS_GND_BIT];
            voltage_ref_source_o <= ref_oh;
            temp_sensor_enable_o <= refctl_q[AIRS_TEMP_BIT];
        end
    end

    sequence s_insel_wr;
        sfr_wr_i && sfr_addr_i == AIRS_INSEL_ADDR;
    endsequence

    sequence s_refctl_wr;
        sfr_wr_i && sfr_addr_i == AIRS_REFCTL_ADDR;
    endsequence

    a_ext_chan_map: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (s_insel_wr and sfr_wdata_i[4] == 1'b0) |-> ##2
            ext_chan_sel_o == (16'h0001 << $past(sfr_wdata_i[3:0], 2)))
        else $error("external channel select wrong");

    a_int_src_map: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (s_insel_wr and sfr_wdata_i[4:0] == AIRS_SEL_GND) |-> ##2
            gnd_chan_sel_o && !temp_chan_sel_o && !vdd_chan_sel_o && !ldo_chan_sel_o)
        else $error("ground select wrong");

    a_temp_src_map: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (s_insel_wr and sfr_wdata_i[4:0] == AIRS_SEL_TEMP) |-> ##2
            temp_chan_sel_o && ext_chan_sel_o == '0)
        else $error("temp sensor select wrong");

    a_ldo_src_map: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (s_insel_wr and sfr_wdata_i[4:0] == AIRS_SEL_LDO) |-> ##2
            ldo_chan_sel_o && ext_chan_sel_o == '0)
        else $error("regulator select wrong");

    a_vdd_src_map: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (s_insel_wr and sfr_wdata_i[4:0] == AIRS_SEL_VDD) |-> ##2
            vdd_chan_sel_o && ext_chan_sel_o == '0)
        else $error("supply select wrong");

    // Two closed switches would short two analog sources together
    a_sel_onehot: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $onehot0({gnd_chan_sel_o, vdd_chan_sel_o, ldo_chan_sel_o, temp_chan_sel_o,
            ext_chan_sel_o}))
        else $error("more than one mux switch closed");

    a_mux_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !(sfr_wr_i && sfr_addr_i == AIRS_INSEL_ADDR) |-> ##2
            $stable({gnd_chan_sel_o, vdd_chan_sel_o, ldo_chan_sel_o, temp_chan_sel_o,
            ext_chan_sel_o}))
        else $error("mux switches moved without a write");

    a_src_onehot: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $onehot(voltage_ref_source_o))
        else $error("reference route not one-hot");

    a_ref_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !(sfr_wr_i && sfr_addr_i == AIRS_REFCTL_ADDR) |-> ##2
            $stable({internal_ref_level_o, ground_ref_select_o, voltage_ref_source_o,
            temp_sensor_enable_o}))
        else $error("reference outputs moved without a write");

    a_reset_vals: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $rose(arst_n_i) |-> insel_q == AIRS_INSEL_RST && refctl_q == AIRS_REFCTL_RST
            && voltage_ref_source_o == AIRS_REF_INT && ext_chan_sel_o == '0)
        else $error("reset values wrong");

    a_refctl_rsvd: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (refctl_q & ~AIRS_REFCTL_WMASK) == 8'h00)
        else $error("reference reserved bit stored");

    a_rd_idle_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !sfr_rd_i |=> sfr_rdata_o == 8'h00)
        else $error("read data nonzero without a read");

    a_unmapped_rd: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        sfr_rd_i && sfr_addr_i != AIRS_INSEL_ADDR && sfr_addr_i != AIRS_REFCTL_ADDR
            |=> sfr_rdata_o == 8'h00)
        else $error("unmapped read nonzero");

    a_rsvd_none: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (s_insel_wr and sfr_wdata_i[4:0] > AIRS_SEL_GND) |-> ##2
            ext_chan_sel_o == '0 && !temp_chan_sel_o && !ldo_chan_sel_o
            && !vdd_chan_sel_o && !gnd_chan_sel_o)
        else $error("reserved code closed a switch");

    a_lvl_follow: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_refctl_wr |-> ##2 internal_ref_level_o == $past(sfr_wdata_i[7], 2))
        else $error("reference level wrong");

    a_gnd_follow: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_refctl_wr |-> ##2 ground_ref_select_o == $past(sfr_wdata_i[5], 2))
        else $error("ground reference wrong");

    a_ref_route: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_refctl_wr |-> ##2
            voltage_ref_source_o == (4'h1 << $past(sfr_wdata_i[4:3], 2)))
        else $error("reference route wrong");

    a_temp_en: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_refctl_wr |-> ##2 temp_sensor_enable_o == $past(sfr_wdata_i[2], 2))
        else $error("temp sensor enable wrong");

    a_rsvd_read: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        sfr_rd_i && sfr_addr_i == AIRS_REFCTL_ADDR
            |=> sfr_rdata_o[1:0] == 2'b00 && !sfr_rdata_o[6])
        else $error("reserved bits read nonzero");

    a_insel_read: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        sfr_rd_i && sfr_addr_i == AIRS_INSEL_ADDR |=> sfr_rdata_o[7:5] == 3'h0)
        else $error("selection upper bits nonzero");
endmodule
`default_nettype wire

// *** airs_core_model.sv ***
// Core-side model: issues single-byte register reads and writes to the select block.
// Assumes requests launch on a rising clk_i edge and are taken at the next one.
`timescale 1ns/100ps
`default_nettype none
module airs_core_model
    import airs_pkg::*;
(
    input wire logic clk_i,             // System clock
    output logic [7:0] sfr_addr_o,      // Register address
    output logic sfr_wr_o,              // Write strobe
    output logic sfr_rd_o,              // Read strobe
    output logic [7:0] sfr_wdata_o,     // Write data
    input wire logic [7:0] sfr_rdata_i  // Read data
);
    initial
    begin
        sfr_addr_o = 8'h00;
        sfr_wdata_o = 8'h00;
        sfr_wr_o = 1'b0;
        sfr_rd_o = 1'b0;
    end
    // Legal writes clear reserved bits; a bench may send raw bytes to test refusal
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic legal);
        @(posedge clk_i);
        sfr_addr_o <= a;
        sfr_wdata_o <= legal ? d & ((a == AIRS_REFCTL_ADDR) ? AIRS_REFCTL_WMASK
            : AIRS_INSEL_WMASK) : d;
        sfr_wr_o <= 1'b1;
        @(posedge clk_i);
        sfr_wr_o <= 1'b0;
        sfr_addr_o <= ~a;
        sfr_wdata_o <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk_i);
        sfr_addr_o <= a;
        sfr_rd_o <= 1'b1;
        @(posedge clk_i);
        sfr_rd_o <= 1'b0;
        sfr_addr_o <= ~a;
        #1;
        q = sfr_rdata_i;
    endtask
endmodule
`default_nettype wire

// *** adc_input_reference_select_bench.sv ***
// Self-checking bench for the converter input and reference select block.
// Assumes the core model is the only bus master; field outputs land two edges after a write.
`timescale 1ns/100ps
`default_nettype none
module adc_input_reference_select_bench
    import airs_pkg::*;
;
    logic clk_i;
    logic arst_n_i;
    logic [7:0] addr, wdata, rdata, q, d;
    logic wr, rd, tmp_s, ldo_s, vdd_s, gnd_s, lvl, gsel, tsen;
    logic [15:0] ext;
    logic [3:0] src, k;
    int error_cnt = 0;
    int n_tests = 0;
    airs_top DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
        .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .ext_chan_sel_o(ext),
        .temp_chan_sel_o(tmp_s), .ldo_chan_sel_o(ldo_s), .vdd_chan_sel_o(vdd_s),
        .gnd_chan_sel_o(gnd_s), .internal_ref_level_o(lvl), .ground_ref_select_o(gsel),
        .voltage_ref_source_o(src), .temp_sensor_enable_o(tsen));
    airs_core_model core (.clk_i(clk_i), .sfr_addr_o(addr), .sfr_wr_o(wr), .sfr_rd_o(rd),
        .sfr_wdata_o(wdata), .sfr_rdata_i(rdata));
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
        n_tests++;
        if (g !== e)
        begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Step past an edge so its register updates have landed
    task automatic settle();
        @(posedge clk_i);
        #1;
    endtask
    initial
    begin
        arst_n_i = 1'b0;
        repeat (4) @(posedge clk_i);
        arst_n_i <= 1'b1;
        settle();
        chk("mux", 20'h0, {gnd_s, vdd_s, ldo_s, tmp_s, ext});
        chk("ref", 20'h8, 20'({lvl, gsel, tsen, src}));
        core.rd(AIRS_INSEL_ADDR, q);
        chk("insel", 20'h1f, 20'(q));
        core.rd(AIRS_REFCTL_ADDR, q);
        chk("refctl", 20'h18, 20'(q));
        for (int c = 0; c < 32; c++)
        begin
            core.wr(AIRS_INSEL_ADDR, 8'(c), 1'b1);
            settle();
            chk("mux", (c < 20) ? 20'h1 << c : 20'h0,
                {gnd_s, vdd_s, ldo_s, tmp_s, ext});
            core.rd(AIRS_INSEL_ADDR, q);
            chk("insel", 20'(c), 20'(q));
        end
        for (int i = 0; i < 16; i++)
        begin
            k = 4'(i);
            d = {k[3], 1'b0, k[2], k[1:0], k[1] ^ k[2], 2'b00};
            core.wr(AIRS_REFCTL_ADDR, d, 1'b1);
            settle();
            chk("ref", {13'h0, k[3], k[2], k[1] ^ k[2], 4'h1 << k[1:0]},
                20'({lvl, gsel, tsen, src}));
            core.rd(AIRS_REFCTL_ADDR, q);
            chk("refctl", 20'(d), 20'(q));
        end
        // Raw bytes with reserved bits set, then a write to an unmapped place
        core.wr(AIRS_INSEL_ADDR, 8'hff, 1'b0);
        core.wr(AIRS_REFCTL_ADDR, 8'hff, 1'b0);
        core.wr(8'h00, 8'h00, 1'b0);
        core.rd(AIRS_INSEL_ADDR, q);
        chk("insel", 20'h1f, 20'(q));
        core.rd(AIRS_REFCTL_ADDR, q);
        chk("refctl", 20'hbc, 20'(q));
        settle();
        chk("rd_idle", 20'h0, 20'(rdata));
        core.rd(8'hbc, q);
        chk("unmapped", 20'h0, 20'(q));
        chk("mux", 20'h0, {gnd_s, vdd_s, ldo_s, tmp_s, ext});
        chk("ref", 20'h78, 20'({lvl, gsel, tsen, src}));
        // Mid-run reset from a non-default state; checked 1 ns in, so a sync-only reset shows
        core.wr(AIRS_INSEL_ADDR, 8'h03, 1'b1);
        @(posedge clk_i);
        arst_n_i <= 1'b0;
        #1;
        chk("mux_in_rst", 20'h0, {gnd_s, vdd_s, ldo_s, tmp_s, ext});
        chk("ref_in_rst", 20'h8, 20'({lvl, gsel, tsen, src}));
        @(posedge clk_i);
        arst_n_i <= 1'b1;
        settle();
        chk("mux_after_rst", 20'h0, {gnd_s, vdd_s, ldo_s, tmp_s, ext});
        core.rd(AIRS_INSEL_ADDR, q);
        chk("insel_after_rst", 20'h1f, 20'(q));
        core.rd(AIRS_REFCTL_ADDR, q);
        chk("refctl_after_rst", 20'h18, 20'(q));
        close_out();
    end
endmodule
`default_nettype wire
